// File: hw/monitor_result_limit_bank.sv
/*
  result and limit register slice of a hardware monitor, offsets 0x25..0x2e,
  with a simple byte-addressed register port behind the serial slave.
  assumes the serial slave and measurement engines run on clk_sys and give
  one-cycle strobes; limits feed the comparison logic outside.
*/
// Functional notes
// - voltage channels five and six results in bits 15:6 at 0x25, 0x26, reset zero.
// - temperature result in bits 15:4, read-only at 0x27, zero after reset.
// - first fan pulse count, 8-bit read-only at 0x28, zero after reset.
// - second fan pulse count, 8-bit read-only at 0x29, zero after reset.
// - 8-bit upper limits for channels zero, one, two at 0x2a, 0x2c, 0x2e.
// - 8-bit lower limits for channels zero and one at 0x2b, 0x2d.
`default_nettype none

module monitor_result_limit_bank
  import monitor_bank_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic volt_ch5_load,
  input wire logic [VOLT_FIELD_W-1:0] volt_ch5_value,
  input wire logic volt_ch6_load,
  input wire logic [VOLT_FIELD_W-1:0] volt_ch6_value,
  input wire logic temp_load,
  input wire logic [TEMP_FIELD_W-1:0] temp_value,
  input wire logic fan1_count_load,
  input wire logic [FAN_FIELD_W-1:0] fan1_count_value,
  input wire logic fan2_count_load,
  input wire logic [FAN_FIELD_W-1:0] fan2_count_value,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [LIMIT_W-1:0] reg_wdata,
  output logic [DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  output logic [LIMIT_W-1:0] volt_ch0_upper_bound,
  output logic [LIMIT_W-1:0] volt_ch0_lower_bound,
  output logic [LIMIT_W-1:0] volt_ch1_upper_bound,
  output logic [LIMIT_W-1:0] volt_ch1_lower_bound,
  output logic [LIMIT_W-1:0] volt_ch2_upper_bound
);

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic logic limit_hit(input logic [ADDR_W-1:0] addr);
    limit_hit = (addr >= OFS_LIMIT_BASE) && (addr <= OFS_LIMIT_LAST);
  endfunction

  function automatic logic [LIMIT_IDX_W-1:0] limit_slot(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] diff;
    diff = addr - OFS_LIMIT_BASE;
    limit_slot = diff[LIMIT_IDX_W-1:0];
  endfunction

  // ----------------------------------------
  // result holders
  // ----------------------------------------
  logic [VOLT_FIELD_W-1:0] volt5_held;
  logic [VOLT_FIELD_W-1:0] volt6_held;
  logic [TEMP_FIELD_W-1:0] temp_held;
  logic [FAN_FIELD_W-1:0] fan1_held;
  logic [FAN_FIELD_W-1:0] fan2_held;

  // holders take no bus input, so a write cannot reach them
  result_holder #(.WIDTH(VOLT_FIELD_W)) u_volt5 (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(volt_ch5_load),
    .value(volt_ch5_value),
    .held(volt5_held)
  );

  result_holder #(.WIDTH(VOLT_FIELD_W)) u_volt6 (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(volt_ch6_load),
    .value(volt_ch6_value),
    .held(volt6_held)
  );

  result_holder #(.WIDTH(TEMP_FIELD_W)) u_temp (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(temp_load),
    .value(temp_value),
    .held(temp_held)
  );

  result_holder #(.WIDTH(FAN_FIELD_W)) u_fan1 (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(fan1_count_load),
    .value(fan1_count_value),
    .held(fan1_held)
  );

  result_holder #(.WIDTH(FAN_FIELD_W)) u_fan2 (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(fan2_count_load),
    .value(fan2_count_value),
    .held(fan2_held)
  );

  // ----------------------------------------
  // limit registers
  // ----------------------------------------
  logic [LIMIT_W-1:0] limit_q [NUM_LIMITS];
  logic [LIMIT_W-1:0] next_limit [NUM_LIMITS];

  always_comb
  begin
    for (int i = 0; i < NUM_LIMITS; i++)
    begin
      next_limit[i] = limit_q[i];
    end
    // only the addressed slot moves; result offsets fall outside the window
    if (reg_wr && limit_hit(reg_addr))
    begin
      next_limit[limit_slot(reg_addr)] = reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_LIMITS; i++)
      begin
        limit_q[i] <= LIMIT_RESET;
      end
    end
    else
    begin
      for (int i = 0; i < NUM_LIMITS; i++)
      begin
        limit_q[i] <= next_limit[i];
      end
    end
  end

  // even slots are upper bounds, odd slots lower bounds
  assign volt_ch0_upper_bound = limit_q[0];
  assign volt_ch0_lower_bound = limit_q[1];
  assign volt_ch1_upper_bound = limit_q[2];
  assign volt_ch1_lower_bound = limit_q[3];
  assign volt_ch2_upper_bound = limit_q[4];

  // ----------------------------------------
  // read port
  // ----------------------------------------
  logic [DATA_W-1:0] next_rdata;
  logic next_rvalid;

  // read data is taken before a same-cycle write lands, so it shows the old value
  always_comb
  begin
    next_rdata = reg_rdata;
    next_rvalid = reg_rd;
    if (reg_rd)
    begin
      if (reg_addr == OFS_VOLT_CH5_RESULT)
      begin
        next_rdata = {volt5_held, {VOLT_FIELD_LSB{1'b0}}};
      end
      else if (reg_addr == OFS_VOLT_CH6_RESULT)
      begin
        next_rdata = {volt6_held, {VOLT_FIELD_LSB{1'b0}}};
      end
      else if (reg_addr == OFS_DIE_TEMPERATURE_RESULT)
      begin
        next_rdata = {temp_held, {TEMP_FIELD_LSB{1'b0}}};
      end
      else if (reg_addr == OFS_FAN1_PULSE_COUNT)
      begin
        next_rdata = {{(DATA_W-FAN_FIELD_W){1'b0}}, fan1_held};
      end
      else if (reg_addr == OFS_FAN2_PULSE_COUNT)
      begin
        next_rdata = {{(DATA_W-FAN_FIELD_W){1'b0}}, fan2_held};
      end
      else if (limit_hit(reg_addr))
      begin
        next_rdata = {{(DATA_W-LIMIT_W){1'b0}}, limit_q[limit_slot(reg_addr)]};
      end
      else
      begin
        next_rdata = UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata <= RESULT_RESET;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rdata <= next_rdata;
      reg_rvalid <= next_rvalid;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  logic ro_write;
  assign ro_write = reg_wr && (reg_addr >= OFS_VOLT_CH5_RESULT) && (reg_addr <= OFS_FAN2_PULSE_COUNT);

  property p_volt5_readback;
    volt_ch5_load ##1 (reg_rd && reg_addr == OFS_VOLT_CH5_RESULT && !volt_ch5_load)
      |=> reg_rvalid && reg_rdata == {$past(volt_ch5_value, 2), 6'h00};
  endproperty
  a_volt5_readback: assert property (p_volt5_readback) else $error("ch5 result not read back");

  property p_volt6_readback;
    reg_rd && reg_addr == OFS_VOLT_CH6_RESULT
      |=> reg_rdata[15:6] == $past(volt6_held) && reg_rdata[5:0] == 6'h00;
  endproperty
  a_volt6_readback: assert property (p_volt6_readback) else $error("ch6 result field wrong");

  property p_temp_readback;
    temp_load ##1 (reg_rd && reg_addr == OFS_DIE_TEMPERATURE_RESULT)
      |=> reg_rdata == {$past(temp_value, 2), 4'h0};
  endproperty
  a_temp_readback: assert property (p_temp_readback) else $error("temperature result wrong");

  property p_fan1_readback;
    reg_rd && reg_addr == OFS_FAN1_PULSE_COUNT |=> reg_rdata == {8'h00, $past(fan1_held)};
  endproperty
  a_fan1_readback: assert property (p_fan1_readback) else $error("fan1 count wrong");

  property p_fan2_readback;
    fan2_count_load ##1 (reg_rd && reg_addr == OFS_FAN2_PULSE_COUNT)
      |=> reg_rdata == {8'h00, $past(fan2_count_value, 2)};
  endproperty
  a_fan2_readback: assert property (p_fan2_readback) else $error("fan2 count wrong");

  // one idle cycle between write and read, as the host model spaces them
  property p_upper_write_read;
    (reg_wr && reg_addr == OFS_VOLT_CH1_UPPER_BOUND) ##1 !reg_wr ##1
      (reg_rd && !reg_wr && reg_addr == OFS_VOLT_CH1_UPPER_BOUND)
      |=> reg_rdata == {8'h00, $past(reg_wdata, 3)} && volt_ch1_upper_bound == $past(reg_wdata, 3);
  endproperty
  a_upper_write_read: assert property (p_upper_write_read) else $error("upper limit write lost");

  property p_lower_write;
    reg_wr && reg_addr == OFS_VOLT_CH0_LOWER_BOUND
      |=> volt_ch0_lower_bound == $past(reg_wdata) && $stable(volt_ch0_upper_bound) && $stable(volt_ch1_upper_bound);
  endproperty
  a_lower_write: assert property (p_lower_write) else $error("lower limit write wrong");

  property p_ro_write_ignored;
    ro_write && !volt_ch5_load && !volt_ch6_load && !temp_load && !fan1_count_load && !fan2_count_load
      |=> $stable(volt5_held) && $stable(volt6_held) && $stable(temp_held) && $stable(fan1_held)
          && $stable(fan2_held) && $stable(volt_ch0_upper_bound) && $stable(volt_ch2_upper_bound);
  endproperty
  a_ro_write_ignored: assert property (p_ro_write_ignored) else $error("read-only write changed state");

  property p_limits_hold;
    !reg_wr [*2] |=> $stable(volt_ch0_upper_bound) && $stable(volt_ch1_lower_bound) && $stable(volt_ch2_upper_bound);
  endproperty
  a_limits_hold: assert property (p_limits_hold) else $error("limit moved without write");

  c_limit_roundtrip: cover property ((reg_wr && reg_addr == OFS_VOLT_CH2_UPPER_BOUND) ##[1:4]
    (reg_rd && reg_addr == OFS_VOLT_CH2_UPPER_BOUND));
  c_temp_read: cover property (temp_load ##[1:4] (reg_rd && reg_addr == OFS_DIE_TEMPERATURE_RESULT));
  c_ro_write: cover property (ro_write ##[1:4] reg_rd);

endmodule // monitor_result_limit_bank

`default_nettype wire

// File: hw/result_holder.sv
/*
  holds the latest result of one measurement channel.
  assumes load and value come from logic on clk_sys.
*/
`default_nettype none

module result_holder #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic load,
  input wire logic [WIDTH-1:0] value,
  output logic [WIDTH-1:0] held
);

  // ----------------------------------------
  // capture
  // ----------------------------------------
  logic [WIDTH-1:0] next_held;

  // only reset and the measurement side can change it, so bus writes never reach here
  always_comb
  begin
    next_held = held;
    if (load)
    begin
      next_held = value;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      held <= '0;
    end
    else
    begin
      held <= next_held;
    end
  end

endmodule // result_holder

`default_nettype wire

// File: inc/monitor_bank_pkg.sv
/*
  constants for the monitor result and limit register slice: offsets,
  field layouts, reset values and widths.
  assumes it is compiled before every design file that imports it.
*/
`default_nettype none

package monitor_bank_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int LIMIT_W = 8;
  localparam int VOLT_FIELD_W = 10;
  localparam int TEMP_FIELD_W = 12;
  localparam int FAN_FIELD_W = 8;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int VOLT_FIELD_LSB = 6;
  localparam int TEMP_FIELD_LSB = 4;
  localparam int FAN_FIELD_LSB = 0;

  // ----------------------------------------
  // offsets
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] OFS_VOLT_CH5_RESULT = 8'h25;
  localparam logic [ADDR_W-1:0] OFS_VOLT_CH6_RESULT = 8'h26;
  localparam logic [ADDR_W-1:0] OFS_DIE_TEMPERATURE_RESULT = 8'h27;
  localparam logic [ADDR_W-1:0] OFS_FAN1_PULSE_COUNT = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_FAN2_PULSE_COUNT = 8'h29;
  localparam logic [ADDR_W-1:0] OFS_VOLT_CH0_UPPER_BOUND = 8'h2a;
  localparam logic [ADDR_W-1:0] OFS_VOLT_CH0_LOWER_BOUND = 8'h2b;
  localparam logic [ADDR_W-1:0] OFS_VOLT_CH1_UPPER_BOUND = 8'h2c;
  localparam logic [ADDR_W-1:0] OFS_VOLT_CH1_LOWER_BOUND = 8'h2d;
  localparam logic [ADDR_W-1:0] OFS_VOLT_CH2_UPPER_BOUND = 8'h2e;

  // limits sit back to back from the first upper bound
  localparam int NUM_LIMITS = 5;
  localparam int LIMIT_IDX_W = 3;
  localparam logic [ADDR_W-1:0] OFS_LIMIT_BASE = OFS_VOLT_CH0_UPPER_BOUND;
  localparam logic [ADDR_W-1:0] OFS_LIMIT_LAST = OFS_VOLT_CH2_UPPER_BOUND;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [DATA_W-1:0] RESULT_RESET = 16'h0000;
  localparam logic [FAN_FIELD_W-1:0] COUNT_RESET = 8'h00;
  localparam logic [LIMIT_W-1:0] LIMIT_RESET = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 16'h0000;

endpackage

`default_nettype wire

// File: tb/host_port_model.sv
/*
  host side of the register port: write and read tasks for the bench.
  assumes one clk_sys domain and a read answer one cycle after the request.
*/
`default_nettype none

module host_port_model (
  input wire logic clk_sys,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // released lines show the inverse, so a stale value never passes as held
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] q, output logic ok);
    int n;
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    ok = 1'b0;
    q = 16'h0000;
    for (n = 0; n < 3 && !ok; n++)
    begin
      #1;
      if (reg_rvalid === 1'b1)
      begin
        ok = 1'b1;
        q = reg_rdata;
      end
      else
        @(posedge clk_sys);
    end
  endtask
endmodule // host_port_model

`default_nettype wire

// File: tb/monitor_result_limit_bank_bench.sv
/*
  self-checking bench for the result and limit register slice.
  assumes the host model above and a one-cycle read answer.
*/
`default_nettype none

module monitor_result_limit_bank_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys;
  logic rst;
  logic [4:0] ld;
  logic [9:0] v5;
  logic [9:0] v6;
  logic [11:0] vt;
  logic [7:0] f1;
  logic [7:0] f2;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic reg_rvalid;
  logic [7:0] lim [5];
  logic [39:0] lim_all;
  int fails;
  int check_count;
  logic [7:0] lim_set [5] = '{8'h5a, 8'ha5, 8'hff, 8'h01, 8'h80};
  logic [15:0] res_exp [5] = '{16'hffc0, 16'h8040, 16'ha5c0, 16'h0081, 16'h007e};

  always #12.5 clk_sys = ~clk_sys;

  assign lim_all = {lim[0], lim[1], lim[2], lim[3], lim[4]};

  monitor_result_limit_bank monitor_result_limit_bank_i (
    .clk_sys(clk_sys), .rst(rst),
    .volt_ch5_load(ld[0]), .volt_ch5_value(v5), .volt_ch6_load(ld[1]), .volt_ch6_value(v6),
    .temp_load(ld[2]), .temp_value(vt), .fan1_count_load(ld[3]), .fan1_count_value(f1),
    .fan2_count_load(ld[4]), .fan2_count_value(f2),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .volt_ch0_upper_bound(lim[0]), .volt_ch0_lower_bound(lim[1]), .volt_ch1_upper_bound(lim[2]),
    .volt_ch1_lower_bound(lim[3]), .volt_ch2_upper_bound(lim[4])
  );

  host_port_model host_port_model_i (
    .clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid)
  );

  task automatic print_verdict();
    if (fails == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [39:0] got, input logic [39:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // a read that never answers ends the run at once
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] q;
    logic ok;
    host_port_model_i.rd(a, q, ok);
    chk("read valid", {39'h0, ok}, 40'h1);
    if (ok !== 1'b1)
      print_verdict();
    chk($sformatf("offset %h", a), {24'h0, q}, {24'h0, exp});
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    rst = 1'b1;
    ld = 5'h00;
    v5 = 10'h000;
    v6 = 10'h000;
    vt = 12'h000;
    f1 = 8'h00;
    f2 = 8'h00;
    fails = 0;
    check_count = 0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    // whole slice plus both unmapped neighbours read zero after reset
    for (int i = 0; i < 12; i++)
      rchk(8'h24 + 8'(i), 16'h0000);
    // each write is read back at once, so a lost write shows on its own offset
    for (int i = 0; i < 5; i++)
    begin
      host_port_model_i.wr(8'h2a + 8'(i), lim_set[i]);
      rchk(8'h2a + 8'(i), {8'h00, lim_set[i]});
    end
    chk("limit ports", lim_all, {lim_set[0], lim_set[1], lim_set[2], lim_set[3], lim_set[4]});
    for (int i = 0; i < 5; i++)
      rchk(8'h2a + 8'(i), {8'h00, lim_set[i]});
    @(posedge clk_sys);
    v5 <= 10'h3ff;
    v6 <= 10'h201;
    vt <= 12'ha5c;
    f1 <= 8'h81;
    f2 <= 8'h7e;
    // each load pulse lands one cycle before the read of its own register
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk_sys);
      ld <= 5'(1 << i);
      fork
        rchk(8'h25 + 8'(i), res_exp[i]);
        begin
          @(posedge clk_sys);
          ld <= 5'h00;
        end
      join
    end
    @(posedge clk_sys);
    v5 <= 10'h000;
    // writes to read-only and unmapped places must not leak anywhere
    for (int i = 0; i < 5; i++)
      host_port_model_i.wr(8'h25 + 8'(i), 8'h3c);
    host_port_model_i.wr(8'h2f, 8'h3c);
    for (int i = 0; i < 5; i++)
      rchk(8'h25 + 8'(i), res_exp[i]);
    chk("limits kept", lim_all, {lim_set[0], lim_set[1], lim_set[2], lim_set[3], lim_set[4]});
    // second reset in mid-run clears results and limits again
    @(posedge clk_sys);
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    chk("limits after reset", lim_all, 40'h0);
    rchk(8'h25, 16'h0000);
    rchk(8'h27, 16'h0000);
    rchk(8'h29, 16'h0000);
    print_verdict();
  end
endmodule // monitor_result_limit_bank_bench

`default_nettype wire
